// file: design/qrf_map.vh
// constants for the quasi-resonant flyback switching control
`ifndef QRF_MAP_VH
`define QRF_MAP_VH

// ----------------------------------------
// clock and timing (ns unless noted)
// ----------------------------------------
`define QRF_CLK_NS          10
`define QRF_LEB_NS          250
`define QRF_SUPP_NS         2500
`define QRF_TON_MAX_NS      12700
`define QRF_PER_MIN_NS      12500
`define QRF_PER_MAX_NS      19231
`define QRF_SS_US           4000
`define QRF_FAULT_US        82000
`define QRF_LEB_CYC         ((`QRF_LEB_NS + `QRF_CLK_NS - 1) / `QRF_CLK_NS)
`define QRF_SUPP_CYC        ((`QRF_SUPP_NS + `QRF_CLK_NS - 1) / `QRF_CLK_NS)
`define QRF_TON_MAX_CYC     (`QRF_TON_MAX_NS / `QRF_CLK_NS)
`define QRF_PER_MIN_CYC     ((`QRF_PER_MIN_NS + `QRF_CLK_NS - 1) / `QRF_CLK_NS)
`define QRF_PER_MAX_CYC     (`QRF_PER_MAX_NS / `QRF_CLK_NS)
`define QRF_SS_CYC          (`QRF_SS_US * 1000 / `QRF_CLK_NS)
`define QRF_FAULT_CYC       (`QRF_FAULT_US * 1000 / `QRF_CLK_NS)

// ----------------------------------------
// ratios and counts
// ----------------------------------------
`define QRF_DUTY_PCT        65
`define QRF_JIT_PCT         4
`define QRF_VALLEY_MAX      8
`define QRF_OVP_RUN         3
// threshold codes in mV
`define QRF_OCP_MIN_MV      450
`define QRF_OCP_MAX_MV      770

`endif

// file: design/qrf_sync2.v
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module qrf_sync2 #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;

   // ----------------------------------------
   // capture then settle; first stage read only by second
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
      end
   end

   assign q_o = s2_q;
endmodule

// file: design/qrf_switch_ctrl.v
// gate timing control for the quasi-resonant flyback converter
//
// Overview of operation
// (R1) foldback picks valley from registered count, max 8
// (R2) burst mode fixes valley count at 8
// (R3) below foldback level, lock valley to load
// (R4) never start cycles faster than 80KHz; with jitter the code starts at down to 96% of that period, about 83KHz
// (R5) full load at 52KHz: fixed frequency CCM
// (R6) feedback above overload level flags overload
// (R7) dither period plus or minus 4% always
// (R8) soft start ramps current limit over 4ms
// (R9) every restart reruns full soft start
// (R10) demag below 0.125V starts a new cycle
// (R11) turn-off starts 2.5us switch-off hold
// (R12) 250ns blanking ignores current comparator
// (R13) current limit 0.45V to 0.77V over 12.7us
// (R14) duty cycle kept to about 65%
// (R15) slope compensation only in fixed-frequency CCM
// (R16) burst: stop below burst level, resume above
// (R17) sample plateau 2.5us after turn-off
// (R18) three overvoltage cycles in a row halt switching
// (R19) shorter overvoltage run clears the counter
// (R20) overvoltage fault recovers via normal startup
// (R21) overload and overcurrent faults trip only after 82ms persistence
// (R22) tripped protection stops until lockout reset
// (R23) all timers from one 10ns clock
`timescale 1ns/1ps
`include "qrf_map.vh"
module qrf_switch_ctrl #(
   parameter SS_CYC    = `QRF_SS_CYC,
   parameter FAULT_CYC = `QRF_FAULT_CYC,
   parameter CW        = 24
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        demag_low_i,
   input  wire        cs_trip_i,
   input  wire        ocp_trip_i,
   input  wire        fb_overload_i,
   input  wire        fb_foldback_i,
   input  wire        fb_burst_i,
   input  wire        ovp_high_i,
   output reg         gate_o,
   output reg  [9:0]  ocp_level_mv_o,
   output reg         slope_comp_o,
   output reg         ovp_sample_o,
   output reg  [3:0]  valley_sel_o,
   output reg         fault_o,
   output reg         burst_o
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   localparam ST_OFF  = 3'b001;
   localparam ST_ON   = 3'b010;
   localparam ST_HALT = 3'b100;
   localparam [CW-1:0] LEB_C   = `QRF_LEB_CYC;                 // R23
   localparam [CW-1:0] SUPP_C  = `QRF_SUPP_CYC;
   localparam [CW-1:0] TONM_C  = `QRF_TON_MAX_CYC;
   localparam [CW-1:0] PMIN_C  = `QRF_PER_MIN_CYC;
   localparam [CW-1:0] PMAX_C  = `QRF_PER_MAX_CYC;
   localparam [CW-1:0] SS_C    = SS_CYC;
   localparam [CW-1:0] FLT_C   = FAULT_CYC;
   localparam [3:0]    VMAX    = `QRF_VALLEY_MAX;
   localparam [1:0]    OVRUN   = `QRF_OVP_RUN;
   localparam [7:0]    DUTY_P  = `QRF_DUTY_PCT;
   localparam [15:0]   OCP_SPAN = `QRF_OCP_MAX_MV - `QRF_OCP_MIN_MV;
   localparam [15:0]   OCP_BASE = `QRF_OCP_MIN_MV;
   localparam          XW      = 48;

   wire [8:0] in_s;
   wire       demag_s, cs_s, ocp_s, ol_s, fold_s, burst_s, ovp_s;
   reg  [2:0]    state_q;
   reg  [CW-1:0] ton_q;
   reg  [CW-1:0] per_q;
   reg  [CW-1:0] ss_q;
   reg  [CW-1:0] flt_q;
   reg  [3:0]    valley_q;
   reg  [3:0]    vcnt_q;
   reg  [1:0]    ovcnt_q;
   reg           ov_seen_q;
   reg           demag_d1_q;
   reg  [5:0]    lfsr_q;
   reg  [CW-1:0] pmin_j_q;
   reg  [CW-1:0] pmax_j_q;
   wire          demag_fall;
   wire          period_ok;
   wire          ccm_force;
   wire          on_end;
   wire          start;
   wire [CW-1:0] ton_lim;
   wire [CW+7:0] duty_w;
   wire [CW-1:0] ton_clip;
   wire [CW-1:0] ss_clip;
   wire [XW-1:0] ramp_w;
   wire [XW-1:0] ocp_w;

   // ----------------------------------------
   // design notes
   // ----------------------------------------
   // all timing is counted in clock cycles; a slower clock needs new counts
   // in the map header, blanking must stay at least one cycle long.
   // period counter runs through on and off time, so off time is per - ton;
   // that keeps one counter for the frequency clamps and the suppression.
   // valleys are counted only after ringing suppression, so the dip that
   // follows turn-off can never count as a valley or start a cycle.
   // burst overrides every start decision and pins the valley at its top,
   // so leaving burst restarts at the slowest valley, not at a stale one.
   // the fault latch has no clear path but reset: recovery is by lockout.
   // jitter moves both clamps together so the duty cap follows the period;
   // the cap is taken against the shortest period, hence a little margin.
   // current limit arithmetic is done wide and cut once at the output,
   // the scaled result never exceeds the 10-bit range because both factors clip.
   // overvoltage run length is two bits: the third hit latches the fault
   // before the counter could wrap.

   // scale a period by (96 + j)%, j in 0..8
   function [CW-1:0] jit;
      input [CW-1:0] p;
      input [3:0]    j;
      reg   [CW+7:0] t;
      begin
         t   = {8'h00, p} * (8'd96 + {4'h0, j});
         t   = t / 100;
         jit = t[CW-1:0];
      end
   endfunction

   // ----------------------------------------
   // input synchronisation
   // ----------------------------------------
   qrf_sync2 #(
      .W (9)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({demag_low_i, cs_trip_i, ocp_trip_i, fb_overload_i, fb_foldback_i,
               fb_burst_i, ovp_high_i, 2'b00}),
      .q_o   (in_s)
   );
   assign {demag_s, cs_s, ocp_s, ol_s, fold_s, burst_s, ovp_s} = in_s[8:2];

   // ----------------------------------------
   // cycle start and end decisions
   // ----------------------------------------
   // valleys counted as falling edges of demag, only after suppression
   assign demag_fall = demag_s & ~demag_d1_q & (per_q >= ton_q + SUPP_C); // R10 R11
   assign period_ok  = per_q >= pmin_j_q;                                 // R4 R7
   // low clamp reached: start anyway, hard switching
   assign ccm_force  = per_q >= pmax_j_q;                                 // R5
   // duty cap of 65% against the fastest period; ton cap 12.7us
   assign duty_w     = {8'h00, pmin_j_q} * {{CW{1'b0}}, DUTY_P} / {{CW{1'b0}}, 8'd100};
   assign ton_lim    = (duty_w < {8'h00, TONM_C}) ? duty_w[CW-1:0] : TONM_C;   // R14
   // blanking masks both comparators after turn-on
   assign on_end     = (ton_q >= LEB_C & (cs_s | ocp_s)) | (ton_q >= ton_lim); // R12 R14
   assign start      = (burst_s ? 1'b0 :                                       // R16
                        (period_ok & ((demag_fall & vcnt_q + 4'd1 >= valley_q) | ccm_force)));

   // ----------------------------------------
   // gate state machine; reset models lockout release
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_OFF;
         gate_o  <= 1'b0;
         ton_q   <= {CW{1'b0}};
         per_q   <= {CW{1'b0}};
         vcnt_q  <= 4'h0;
      end else begin
         case (state_q)
            ST_OFF: begin
               per_q <= per_q + 1'b1;
               if (demag_fall)
                  vcnt_q <= vcnt_q + 4'd1;
               if (fault_o) begin
                  state_q <= ST_HALT;                              // R22
               end else if (start) begin
                  state_q <= ST_ON;
                  gate_o  <= 1'b1;                                 // R10
                  ton_q   <= {CW{1'b0}};
                  per_q   <= {CW{1'b0}};
                  vcnt_q  <= 4'h0;
               end
            end
            ST_ON: begin
               per_q <= per_q + 1'b1;
               ton_q <= ton_q + 1'b1;
               if (fault_o | on_end) begin
                  state_q <= fault_o ? ST_HALT : ST_OFF;
                  gate_o  <= 1'b0;                                 // R11
               end
            end
            ST_HALT: begin
               gate_o <= 1'b0;                                     // R18 R20 R22
            end
            default: begin
               state_q <= ST_OFF;
               gate_o  <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // valley lock, jitter, soft start, burst flag
   // ----------------------------------------
   // in foldback the valley moves at most one step per cycle, locking it against audio chatter; outside foldback it drops to 1, burst pins it at 8
   always @(posedge clk_i) begin
      if (rst_i) begin
         valley_q   <= 4'h1;
         demag_d1_q <= 1'b0;
         lfsr_q     <= 6'h2D;
         pmin_j_q   <= PMIN_C;
         pmax_j_q   <= PMAX_C;
         ss_q       <= {CW{1'b0}};
         burst_o    <= 1'b0;
      end else begin
         demag_d1_q <= demag_s;
         burst_o    <= burst_s;
         if (ss_q < SS_C)
            ss_q <= ss_q + 1'b1;                                   // R8 R9
         // burst blocks every start, so the valley is pinned here, not at a start
         if (burst_s)
            valley_q <= VMAX;                                      // R2
         if (state_q == ST_OFF && start) begin
            lfsr_q   <= {lfsr_q[4:0], lfsr_q[5] ^ lfsr_q[4]};
            pmin_j_q <= jit(PMIN_C, {1'b0, lfsr_q[2:0]} + {3'h0, lfsr_q[3]}); // R7
            pmax_j_q <= jit(PMAX_C, {1'b0, lfsr_q[2:0]} + {3'h0, lfsr_q[3]}); // R7
            if (!fold_s)
               valley_q <= 4'h1;
            else if (ccm_force && valley_q > 4'h1)
               valley_q <= valley_q - 4'd1;                        // R3
            else if (!ccm_force && per_q < pmin_j_q + SUPP_C && valley_q < VMAX)
               valley_q <= valley_q + 4'd1;                        // R1 R3
         end
      end
   end

   // ----------------------------------------
   // current limit ramp
   // ----------------------------------------
   // on time clipped at 12.7us, then scaled by the soft start fraction
   assign ton_clip = (ton_q >= TONM_C) ? TONM_C : ton_q;                      // R13
   assign ss_clip  = (ss_q >= SS_C) ? SS_C : ss_q;                            // R8
   assign ramp_w   = {{(XW-CW){1'b0}}, ton_clip} * {{(XW-16){1'b0}}, OCP_SPAN}
                     / {{(XW-CW){1'b0}}, TONM_C} + {{(XW-16){1'b0}}, OCP_BASE};
   assign ocp_w    = ramp_w * {{(XW-CW){1'b0}}, ss_clip} / {{(XW-CW){1'b0}}, SS_C};

   // ----------------------------------------
   // outputs from flops
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ocp_level_mv_o <= 10'h000;
         slope_comp_o   <= 1'b0;
         valley_sel_o   <= 4'h1;
      end else begin
         valley_sel_o <= valley_q;                                 // R1
         // ramp with on time, then scaled by soft start fraction
         ocp_level_mv_o <= ocp_w[9:0];                             // R13 R8
         if (state_q == ST_OFF && start)
            slope_comp_o <= ccm_force & ~fold_s;                   // R15
      end
   end

   // ----------------------------------------
   // overvoltage plateau sampling and fault timers
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ovp_sample_o <= 1'b0;
         ovcnt_q      <= 2'h0;
         ov_seen_q    <= 1'b0;
         flt_q        <= {CW{1'b0}};
         fault_o      <= 1'b0;
      end else begin
         ovp_sample_o <= 1'b0;
         if (state_q == ST_ON && (fault_o | on_end))
            ov_seen_q <= 1'b0;
         if (state_q == ST_OFF && per_q == ton_q + SUPP_C) begin
            ovp_sample_o <= 1'b1;                                  // R17
            ov_seen_q    <= 1'b1;
            if (ovp_s)
               ovcnt_q <= ovcnt_q + 2'd1;                          // R18
            else
               ovcnt_q <= 2'h0;                                    // R19
         end
         // overload or overcurrent must persist before tripping
         if (ol_s | ocp_s)
            flt_q <= (flt_q < FLT_C) ? flt_q + 1'b1 : flt_q;       // R6 R21
         else
            flt_q <= {CW{1'b0}};
         if (flt_q >= FLT_C || ovcnt_q >= OVRUN)
            fault_o <= 1'b1;                                       // R18 R20 R22
      end
   end
endmodule

// file: testbench/qrf_props.sv
// port assertions for the switching control
`timescale 1ns/1ps
module qrf_props (
   input wire       clk_i,
   input wire       rst_i,
   input wire       gate_o,
   input wire [9:0] ocp_level_mv_o,
   input wire       slope_comp_o,
   input wire       ovp_sample_o,
   input wire [3:0] valley_sel_o,
   input wire       fault_o,
   input wire       burst_o
);
   reg        gate_q;
   reg [15:0] on_q, off_q, idle_q, per_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // run lengths; period saturates so the first start after reset is never judged
   always @(posedge clk_i) begin
      gate_q <= gate_o;
      on_q   <= (rst_i || !gate_o) ? 16'h0000 : on_q + 16'h0001;
      off_q  <= (rst_i || gate_o) ? 16'h0000 : off_q + 16'h0001;
      idle_q <= (rst_i || gate_o || burst_o || fault_o) ? 16'h0000 : idle_q + 16'h0001;
      per_q  <= rst_i ? 16'hFFFF : (gate_o && !gate_q) ? 16'h0000 :
                per_q + {15'h0000, per_q != 16'hFFFF};
   end
   chk_valley_range: assert property (valley_sel_o >= 4'h1 && valley_sel_o <= 4'h8)
      else $error("valley selection out of range");
   chk_burst_valley: assert property (burst_o && $past(burst_o) |-> valley_sel_o == 4'h8)
      else $error("valley not fixed in burst");
   chk_min_period: assert property ($rose(gate_o) |-> per_q >= 16'd1199)
      else $error("cycle started too early");
   chk_max_idle: assert property (!gate_o |-> idle_q <= 16'd1995)
      else $error("forced start missing");
   chk_blank_min: assert property ($fell(gate_o) && !fault_o |-> on_q >= 16'd25)
      else $error("pulse ended inside blanking");
   chk_ocp_clamp: assert property (ocp_level_mv_o <= 10'd770)
      else $error("current limit above clamp");
   chk_duty_cap: assert property (gate_o |-> on_q <= 16'd845)
      else $error("on time above duty cap");
   chk_burst_stop: assert property (burst_o |-> !$rose(gate_o))
      else $error("start during burst stop");
   chk_plateau_time: assert property (ovp_sample_o |-> !gate_o && off_q inside {[247:253]})
      else $error("plateau sample misplaced");
   chk_fault_hold: assert property (fault_o |=> fault_o && !gate_o)
      else $error("fault released or gate on");
   cover property ($rose(gate_o));
   cover property ($rose(fault_o));
   cover property ($rose(burst_o));
   cover property ($rose(slope_comp_o));
endmodule

// file: testbench/qrf_plant.sv
// behavioural power switch and auxiliary winding
`timescale 1ns/1ps
module qrf_plant (
   input  wire        clk_i,
   input  wire        gate_i,
   input  wire [15:0] on_cyc_i,
   input  wire [15:0] demag_cyc_i,
   input  wire        ovp_on_i,
   output reg         demag_low_o,
   output reg         cs_trip_o,
   output reg         ovp_high_o
);
   reg        gate_q = 1'b0;
   reg [15:0] cnt_q  = 16'h0000;
   // one counter restarts at each gate edge and saturates; a short dip mimics
   // leakage ringing, and after demag the winding rings with a valley every 128 cycles
   always @(posedge clk_i) begin
      gate_q      <= gate_i;
      cnt_q       <= (gate_i !== gate_q) ? 16'h0000 : cnt_q + {15'h0000, cnt_q != 16'hFFFF};
      cs_trip_o   <= gate_i && cnt_q >= on_cyc_i;
      ovp_high_o  <= ovp_on_i && !gate_i && cnt_q < demag_cyc_i;
      demag_low_o <= !gate_i && ((cnt_q >= demag_cyc_i && cnt_q[6]) ||
                     (cnt_q > 10 && cnt_q < 20));
   end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the switching control
`timescale 1ns/1ps
module testbench;
   reg        clk_i, rst_i, ocp_trip_i, fb_overload_i, fb_foldback_i, fb_burst_i, ovp_on, gq;
   reg [15:0] on_cyc, demag_cyc;
   reg [9:0]  ocp_full, a;
   wire       demag_low_i, cs_trip_i, ovp_high_i, gate_o, slope_comp_o, ovp_sample_o;
   wire       fault_o, burst_o;
   wire [9:0] ocp_level_mv_o;
   wire [3:0] valley_sel_o;
   integer    fails, n_compared, rises, r0, k;
   qrf_switch_ctrl #(.SS_CYC(4000), .FAULT_CYC(3000)) qrf_switch_ctrl_inst (.clk_i, .rst_i,
      .demag_low_i, .cs_trip_i, .ocp_trip_i, .fb_overload_i, .fb_foldback_i, .fb_burst_i,
      .ovp_high_i, .gate_o, .ocp_level_mv_o, .slope_comp_o, .ovp_sample_o, .valley_sel_o,
      .fault_o, .burst_o);
   qrf_plant qrf_plant_inst (.clk_i, .gate_i(gate_o), .on_cyc_i(on_cyc), .demag_cyc_i(demag_cyc),
      .ovp_on_i(ovp_on), .demag_low_o(demag_low_i), .cs_trip_o(cs_trip_i),
      .ovp_high_o(ovp_high_i));
   // clock and start counter
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      gq <= gate_o;
      if (gate_o === 1'b1 && gq === 1'b0) rises <= rises + 1;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task results;
      begin
         if (fails == 0 && n_compared > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task cmp(input string what, input [15:0] exp, input [15:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR %0s expected %0h seen %0h", what, exp, got);
         end
      end
   endtask
   task step(input integer n);
      begin
         repeat (n) @(posedge clk_i);
         #1;
      end
   endtask
   // bounded wait for a gate level; a hang counts as a mismatch
   task wait_lvl(input v);
      begin
         k = 0;
         while (gate_o !== v && k < 3000) begin
            step(1);
            k = k + 1;
         end
         cmp("gate_wait", 1, k < 3000);
      end
   endtask
   task pulse_ocp(output [9:0] v);
      begin
         wait_lvl(1'b0);
         wait_lvl(1'b1);
         step(100);
         v = ocp_level_mv_o;
      end
   endtask
   task do_reset;
      begin
         rst_i = 1'b1;
         step(3);
         cmp("gate_rst", 0, gate_o);
         cmp("valley_rst", 1, valley_sel_o);
         cmp("fault_rst", 0, fault_o);
         cmp("ocp_rst", 0, ocp_level_mv_o);
         rst_i = 1'b0;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_softstart;
      begin
         do_reset;
         pulse_ocp(a);
         step(3000);
         pulse_ocp(ocp_full);
         cmp("ss_rise", 1, a < ocp_full);
         cmp("ocp_band", 1, ocp_full >= 10'd450 && ocp_full <= 10'd770);
      end
   endtask
   task t_qr_ccm;
      begin
         r0 = rises;
         step(12000);
         cmp("qr_starts", 1, rises - r0 >= 8 && rises - r0 <= 10);
         cmp("slope_qr", 0, slope_comp_o);
         demag_cyc = 16'hFFFF;
         step(2500);
         r0 = rises;
         step(10000);
         cmp("ccm_starts", 1, rises - r0 >= 5 && rises - r0 <= 6);
         cmp("slope_ccm", 1, slope_comp_o);
         demag_cyc = 16'd600;
         step(4000);
         cmp("slope_off", 0, slope_comp_o);
      end
   endtask
   // no current trip: the pulse must end at 65% of the jittered minimum period
   task t_duty;
      begin
         on_cyc = 16'hFFFF;
         wait_lvl(1'b0);
         wait_lvl(1'b1);
         wait_lvl(1'b0);
         cmp("duty_cap", 1, k >= 779 && k <= 846);
         on_cyc = 16'd300;
      end
   endtask
   task t_foldback_burst;
      begin
         fb_foldback_i = 1'b1;
         step(10000);
         cmp("valley_lock", 1, valley_sel_o >= 4'h1 && valley_sel_o <= 4'h8);
         fb_burst_i = 1'b1;
         step(20);
         r0 = rises;
         step(4000);
         cmp("burst_flag", 1, burst_o);
         cmp("burst_valley", 8, valley_sel_o);
         cmp("burst_quiet", r0, rises);
         fb_burst_i = 1'b0;
         fb_foldback_i = 1'b0;
         step(2500);
         cmp("burst_resume", 1, rises > r0);
      end
   endtask
   task t_ovp;
      begin
         wait_lvl(1'b1);
         ovp_on = 1'b1;
         repeat (2) pulse_ocp(a);
         ovp_on = 1'b0;
         step(5000);
         cmp("ovp_short", 0, fault_o);
         ovp_on = 1'b1;
         step(8000);
         ovp_on = 1'b0;
         r0 = rises;
         step(3000);
         cmp("ovp_fault", 1, fault_o);
         cmp("ovp_halt", r0, rises);
         do_reset;
         pulse_ocp(a);
         cmp("ss_again", 1, a < ocp_full);
      end
   endtask
   task t_overload;
      begin
         ocp_trip_i = 1'b1;
         step(2000);
         ocp_trip_i = 1'b0;
         step(100);
         cmp("olp_short", 0, fault_o);
         fb_overload_i = 1'b1;
         step(3200);
         cmp("olp_fault", 1, fault_o);
         r0 = rises;
         step(3000);
         cmp("olp_halt", r0, rises);
         fb_overload_i = 1'b0;
         do_reset;
         step(3000);
         cmp("olp_restart", 1, rises > r0);
      end
   endtask
   // watchdog sized only slightly beyond the planned run
   initial begin
      #980000;
      fails = fails + 1;
      results;
   end
   initial begin
      {rst_i, ocp_trip_i, fb_overload_i, fb_foldback_i, fb_burst_i, ovp_on, gq} = 7'h40;
      on_cyc = 16'd300;
      demag_cyc = 16'd600;
      fails = 0;
      n_compared = 0;
      rises = 0;
      t_softstart;
      t_qr_ccm;
      t_duty;
      t_foldback_burst;
      t_ovp;
      t_overload;
      results;
   end
endmodule
bind qrf_switch_ctrl qrf_props qrf_props_inst (.clk_i, .rst_i, .gate_o, .ocp_level_mv_o,
   .slope_comp_o, .ovp_sample_o, .valley_sel_o, .fault_o, .burst_o);
